// *** hw/voice_data_channel_manipulation.sv ***
// voice data channel manipulation: register port, fifo, link slot engine
// assumes an 8-bit register write port and a frame strobe on link_clk_i
`timescale 1ns/1ps
`default_nettype none
`include "vdm_regs.svh"

// ==========================================
// fifo
module vdm_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wp_q;
  logic [AW:0]      rp_q;
  logic             full;
  logic             empty;
  assign full        = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
  assign empty       = (wp_q == rp_q);
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_q[rp_q[AW-1:0]];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (in_valid_i && !full) begin
        wp_q <= wp_q + 1'b1;
      end
      if (out_ready_i && !empty) begin
        rp_q <= rp_q + 1'b1;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (in_valid_i && !full) begin
      mem_q[wp_q[AW-1:0]] <= in_data_i;
    end
  end
endmodule

// ==========================================
// top
module voice_data_channel_manipulation (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        reg_wr_i,
  input  wire logic [3:0]  reg_sel_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  input  wire logic        strap_i,
  input  wire logic        tx_valid_i,
  output logic             tx_ready_o,
  input  wire logic [15:0] tx_sample_i,
  output logic             rx_valid_o,
  output logic      [15:0] rx_sample_o,
  output logic             rx_hs_o,
  output logic             rx_spk_o,
  input  wire logic        link_clk_i,
  input  wire logic        frame_i,
  input  wire logic [7:0]  dd_byte_i,
  input  wire logic [7:0]  du_byte_i,
  output logic      [7:0]  du_byte_o,
  output logic             du_oe_o
);
  // ==========================================
  // register side
  typedef struct packed {
    logic [7:0] cmd;
    logic [7:0] gcr;
    logic [7:0] fmt;
    logic [1:0] strap_sync;
    logic [7:0] rdata;
    logic [2:0] rx_tsync;
    logic       rx_valid;
    logic [15:0] rx_sample;
    logic       rx_hs;
    logic       rx_spk;
  } ref_state_s;
  ref_state_s r_q;
  ref_state_s r_d;
  vdm_pkg::chan_cfg_s cfg_req;
  logic [15:0] fifo_data;
  logic        fifo_valid;
  logic        fifo_pop;
  vdm_pkg::pair_s rx_pair_x;
  logic           rx_tgl_x;
  logic           hs_x;
  logic           spk_x;

  always_comb begin
    cfg_req        = '0;
    cfg_req.mode   = r_q.fmt[`VDM_FMT_VDM_HI:0];
    cfg_req.reverse_channel_select    = r_q.cmd[`VDM_CMD_RCM_BIT];
    cfg_req.slot   = r_q.gcr[`VDM_GCR_SLOT_BIT];
    cfg_req.chip_addressing_mode    = r_q.gcr[`VDM_GCR_CAM_BIT];
    cfg_req.voice_transmit_enable    = r_q.gcr[`VDM_GCR_EVX_BIT];
    cfg_req.strap  = r_q.strap_sync[1];
    cfg_req.hs_en  = r_q.fmt[`VDM_FMT_HS_BIT];
    cfg_req.spk_en = r_q.fmt[`VDM_FMT_SPK_BIT];
  end

  always_comb begin
    r_d            = r_q;
    r_d.strap_sync = {r_q.strap_sync[0], strap_i};
    r_d.rx_tsync   = {r_q.rx_tsync[1:0], rx_tgl_x};
    r_d.rx_valid   = 1'b0;
    if (reg_wr_i) begin
      case (reg_sel_i)
        `VDM_SEL_CMD: begin
          // rcm only takes effect on a write command
          if (!reg_wdata_i[`VDM_CMD_RW_BIT]) begin
            r_d.cmd = reg_wdata_i;
          end else begin
            r_d.cmd[`VDM_CMD_RW_BIT] = 1'b1;
          end
        end
        `VDM_SEL_GCR: r_d.gcr = reg_wdata_i;
        `VDM_SEL_FMT: r_d.fmt = reg_wdata_i;
        default: r_d.cmd = r_q.cmd;
      endcase
    end
    case (reg_sel_i)
      `VDM_SEL_CMD: r_d.rdata = r_q.cmd;
      `VDM_SEL_GCR: r_d.rdata = r_q.gcr;
      `VDM_SEL_FMT: r_d.rdata = r_q.fmt;
      default:      r_d.rdata = 8'h00;
    endcase
    if (r_q.rx_tsync[2] != r_q.rx_tsync[1]) begin
      r_d.rx_valid  = 1'b1;
      r_d.rx_sample = {rx_pair_x.a, rx_pair_x.b};
      r_d.rx_hs     = hs_x;
      r_d.rx_spk    = spk_x;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r_q           <= '0;
      r_q.cmd       <= `VDM_CMD_RST;
      r_q.gcr       <= `VDM_GCR_RST;
      r_q.fmt       <= `VDM_FMT_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign reg_rdata_o = r_q.rdata;
  assign rx_valid_o  = r_q.rx_valid;
  assign rx_sample_o = r_q.rx_sample;
  assign rx_hs_o     = r_q.rx_hs;
  assign rx_spk_o    = r_q.rx_spk;

  vdm_fifo #(
    .WIDTH(16),
    .DEPTH(8)
  ) u_fifo (
    .clk_i      (ref_clk_i),
    .rst_n_i    (rst_n_i),
    .in_valid_i (tx_valid_i),
    .in_ready_o (tx_ready_o),
    .in_data_i  (tx_sample_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(fifo_pop),
    .out_data_o (fifo_data)
  );

  // ==========================================
  // link side
  typedef struct packed {
    vdm_pkg::chan_cfg_s cfg_s1;
    vdm_pkg::chan_cfg_s cfg_s2;
    vdm_pkg::chan_cfg_s cfg_s3;
    vdm_pkg::chan_cfg_s cfg_pend;
    vdm_pkg::chan_cfg_s cfg;
    logic [2:0]  slot_cnt;
    logic [7:0]  rx_a;
    logic [7:0]  rx_b;
    vdm_pkg::pair_s rx_out;
    logic        rx_tgl;
    logic        rx_hs;
    logic        rx_spk;
    logic [15:0] tx_word;
    logic [7:0]  du_byte;
    logic        du_oe;
    logic [2:0]  pop_ack;
  } link_state_s;
  link_state_s l_q;
  link_state_s l_d;
  logic        pop_tgl_q;
  logic [2:0]  pop_sync_q;
  logic        pop_req_q;

  // slot selection helpers
  logic       lin_or_conf;
  logic       is_conf;
  logic       is_mon;
  logic       rx_on;
  logic       second;
  logic [2:0] first_slot;
  logic [2:0] sec_slot;
  logic [2:0] sel_slot;

  always_comb begin
    is_conf     = (l_q.cfg.mode == `VDM_MODE_CONF);
    is_mon      = (l_q.cfg.mode == `VDM_MODE_MON);
    lin_or_conf = (l_q.cfg.mode == `VDM_MODE_LIN_TX) ||
                  (l_q.cfg.mode == `VDM_MODE_LIN_TXRX) || is_conf;
    rx_on       = (l_q.cfg.mode == `VDM_MODE_TXRX) ||
                  (l_q.cfg.mode == `VDM_MODE_LIN_TXRX) || is_conf || is_mon;
    second      = l_q.cfg.reverse_channel_select ^ (l_q.cfg.strap & !l_q.cfg.chip_addressing_mode);
    first_slot  = l_q.cfg.slot ? `VDM_SLOT_IC1 : `VDM_SLOT_B1;
    sec_slot    = l_q.cfg.slot ? `VDM_SLOT_IC2 : `VDM_SLOT_B2;
    sel_slot    = second ? sec_slot : first_slot;
  end

  always_comb begin
    l_d          = l_q;
    // quasi-static setup crossing: take it once two samples agree
    l_d.cfg_s1   = cfg_req;
    l_d.cfg_s2   = l_q.cfg_s1;
    l_d.cfg_s3   = l_q.cfg_s2;
    if (l_q.cfg_s3 == l_q.cfg_s2) begin
      l_d.cfg_pend = l_q.cfg_s3;
    end
    l_d.du_oe    = 1'b0;
    l_d.du_byte  = 8'h00;
    if (frame_i) begin
      l_d.slot_cnt = 3'h0;
      // new setup only between frames
      l_d.cfg      = l_q.cfg_pend;
      l_d.tx_word  = fifo_data;
      if (lin_or_conf) begin
        l_d.rx_out  = '{a: l_q.rx_a, b: l_q.rx_b};
      end else begin
        l_d.rx_out  = '{a: l_q.rx_a, b: 8'h00};
      end
      if (rx_on) begin
        l_d.rx_tgl = !l_q.rx_tgl;
        l_d.rx_hs  = l_q.cfg.hs_en;
        l_d.rx_spk = l_q.cfg.spk_en;
      end
    end else if (l_q.slot_cnt != `VDM_SLOT_LAST) begin
      l_d.slot_cnt = l_q.slot_cnt + 3'h1;
    end
    if (lin_or_conf) begin
      if (l_q.slot_cnt == first_slot) begin
        l_d.rx_a    = dd_byte_i;
        l_d.du_byte = l_q.tx_word[15:8];
        l_d.du_oe   = l_q.cfg.voice_transmit_enable;
      end else if (l_q.slot_cnt == sec_slot) begin
        if (is_conf) begin
          l_d.rx_a    = 8'(l_q.rx_a + dd_byte_i);
          l_d.du_byte = l_q.tx_word[15:8];
        end else begin
          l_d.rx_b    = dd_byte_i;
          l_d.du_byte = l_q.tx_word[7:0];
        end
        l_d.du_oe   = l_q.cfg.voice_transmit_enable;
      end
    end else if (l_q.slot_cnt == sel_slot) begin
      if (is_mon) begin
        l_d.rx_a = 8'(dd_byte_i + du_byte_i);
      end else begin
        l_d.rx_a = dd_byte_i;
      end
      l_d.du_byte = l_q.tx_word[15:8];
      l_d.du_oe   = l_q.cfg.voice_transmit_enable;
    end
    if (!rx_on) begin
      l_d.rx_a = 8'h00;
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      l_q       <= '0;
      pop_tgl_q <= 1'b0;
    end else begin
      l_q <= l_d;
      if (frame_i) begin
        pop_tgl_q <= !pop_tgl_q;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pop_sync_q <= '0;
      pop_req_q  <= 1'b0;
    end else begin
      pop_sync_q <= {pop_sync_q[1:0], pop_tgl_q};
      pop_req_q  <= (pop_sync_q[2] != pop_sync_q[1]) && fifo_valid;
    end
  end

  assign fifo_pop  = pop_req_q;
  assign rx_pair_x = l_q.rx_out;
  assign rx_tgl_x  = l_q.rx_tgl;
  assign hs_x      = l_q.rx_hs;
  assign spk_x     = l_q.rx_spk;
  assign du_byte_o = l_q.du_byte;
  assign du_oe_o   = l_q.du_oe;
endmodule
`default_nettype wire

// *** hw/vdm_regs.svh ***
// constants for the voice data channel manipulation block
// assumes a frame strobe on the link clock and 8-bit timeslots
// What this block does
// - route received byte to handset, speaker, both
// - normal mode: 0000 transmit only, 0001 both
// - strap swaps pair choice unless chip addressing mode is set; slot picks intercom
// - linear mode 0100 transmit, 0101 both
// - linear treats pair as 16-bit sample
// - first channel byte precedes second byte
// - conferencing code 1000 uses chosen pair
// - conference receive is 8-bit byte sum
// - conference transmits same byte in both
// - monitoring code 1100 transmits selected channel
// - monitor receive sums downstream and upstream
// - registers reachable by the 8-bit register port
// - reverse select 0 first channel, 1 second
`ifndef VDM_REGS_SVH
`define VDM_REGS_SVH
// ==========================================
// register select codes
`define VDM_SEL_GCR        4'h0
`define VDM_SEL_FMT        4'h1
`define VDM_SEL_CMD        4'hb
// ==========================================
// field positions
`define VDM_CMD_RW_BIT     7
`define VDM_CMD_RCM_BIT    6
`define VDM_GCR_EVX_BIT    4
`define VDM_GCR_SLOT_BIT   3
`define VDM_GCR_CAM_BIT    1
`define VDM_FMT_VDM_HI     3
`define VDM_FMT_SPK_BIT    4
`define VDM_FMT_HS_BIT     5
// ==========================================
// reset values
`define VDM_CMD_RST        8'hbf
`define VDM_GCR_RST        8'h00
`define VDM_FMT_RST        8'h20
// ==========================================
// modes
`define VDM_MODE_TXONLY    4'h0
`define VDM_MODE_TXRX      4'h1
`define VDM_MODE_LIN_TX    4'h4
`define VDM_MODE_LIN_TXRX  4'h5
`define VDM_MODE_CONF      4'h8
`define VDM_MODE_MON       4'hc
// ==========================================
// slot indices within a frame
`define VDM_SLOT_B1        3'h0
`define VDM_SLOT_B2        3'h1
`define VDM_SLOT_IC1       3'h4
`define VDM_SLOT_IC2       3'h5
`define VDM_SLOT_LAST      3'h7
`endif

// *** hw/vdm_pkg.sv ***
// types for the voice data channel manipulation block
// assumes vdm_regs.svh constants
package vdm_pkg;
  typedef struct packed {
    logic [3:0] mode;
    logic       reverse_channel_select;
    logic       slot;
    logic       chip_addressing_mode;
    logic       voice_transmit_enable;
    logic       strap;
    logic       hs_en;
    logic       spk_en;
  } chan_cfg_s;
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
  } pair_s;
endpackage

// *** dv/vdm_sva.sv ***
// port checker for the voice data channel manipulation block
// assumes it is bound onto the top module
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// checker
module vdm_sva (
  input wire logic        ref_clk_i,
  input wire logic        rst_n_i,
  input wire logic        reg_wr_i,
  input wire logic [3:0]  reg_sel_i,
  input wire logic [7:0]  reg_wdata_i,
  input wire logic [7:0]  reg_rdata_o,
  input wire logic        rx_valid_o,
  input wire logic [15:0] rx_sample_o,
  input wire logic        link_clk_i,
  input wire logic        du_oe_o
);
  sequence s_wr(s);
    reg_wr_i && reg_sel_i == s;
  endsequence
  sequence s_hold(s);
    !reg_wr_i && reg_sel_i == s;
  endsequence
  property p_rb(s);
    @(posedge ref_clk_i) disable iff (!rst_n_i)
      s_wr(s) ##1 s_hold(s) |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_gcr_readback:
    assert property (p_rb(4'h0)) else $error("gcr readback wrong");
  a_fmt_readback:
    assert property (p_rb(4'h1)) else $error("format readback wrong");
  a_rcm_refused:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_wr_i && reg_sel_i == 4'hb && reg_wdata_i[7] ##1 s_hold(4'hb)
      |=> reg_rdata_o[6] == $past(reg_rdata_o[6])) else $error("reverse select moved");
  a_unmapped_lo:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      reg_sel_i == 4'h5 |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_unmapped_hi:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      (reg_sel_i == 4'hf) [*2] |-> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rx_spacing:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      rx_valid_o |=> !rx_valid_o [*8]) else $error("sample pulses too close");
  a_rx_hold:
    assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      $changed(rx_sample_o) |-> rx_valid_o) else $error("sample moved without pulse");
  a_oe_two_slots:
    assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
      du_oe_o ##1 du_oe_o |=> !du_oe_o) else $error("drive longer than two slots");
endmodule
bind voice_data_channel_manipulation vdm_sva CHK (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_wr_i(reg_wr_i), .reg_sel_i(reg_sel_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .rx_valid_o(rx_valid_o),
  .rx_sample_o(rx_sample_o), .link_clk_i(link_clk_i), .du_oe_o(du_oe_o));
`default_nettype wire

// *** dv/vdm_link_model.sv ***
// link partner: frame strobe, slot bytes, upstream capture
// assumes the bench loads both tables before traffic
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// link model
module vdm_link_model (
  input  wire logic       link_clk_i,
  output logic            frame_o,
  output logic      [7:0] dd_o,
  output logic      [7:0] du_o,
  input  wire logic [7:0] du_byte_i,
  input  wire logic       du_oe_i
);
  logic [7:0] dd_tab [8];
  logic [7:0] du_tab [8];
  logic [7:0] got [$];
  logic [2:0] cnt = 3'h0;
  // slots move off the sampling edge
  always @(negedge link_clk_i) cnt <= cnt + 3'h1;
  // strobe one cycle ahead of slot 0
  assign frame_o = cnt == 3'h7;
  assign dd_o    = dd_tab[cnt];
  // other talker fills upstream where the block is silent
  assign du_o    = du_oe_i ? du_byte_i : du_tab[cnt];
  // capture off the launching edge of the block's drive
  always @(negedge link_clk_i) if (du_oe_i) got.push_back(du_byte_i);
endmodule
`default_nettype wire

// *** dv/voice_data_channel_manipulation_bench.sv ***
// self-checking bench for the voice data channel manipulation block
// assumes the link model and the bound checker
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench
module voice_data_channel_manipulation_bench;
  logic        ref_clk, link_clk, frame, oe, txr, rxv, hs, spk;
  logic        rst_n = 1'b0, wr = 1'b0, strap = 1'b0, txv = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  wd = 8'h00, rdat, dd, du, dub;
  logic [15:0] txs = 16'h0000, rxs;
  int          miscompares = 0, total_checks = 0, n;
  voice_data_channel_manipulation DUT (
    .ref_clk_i(ref_clk), .rst_n_i(rst_n), .reg_wr_i(wr), .reg_sel_i(sel),
    .reg_wdata_i(wd), .reg_rdata_o(rdat), .strap_i(strap), .tx_valid_i(txv),
    .tx_ready_o(txr), .tx_sample_i(txs), .rx_valid_o(rxv), .rx_sample_o(rxs),
    .rx_hs_o(hs), .rx_spk_o(spk), .link_clk_i(link_clk), .frame_i(frame),
    .dd_byte_i(dd), .du_byte_i(du), .du_byte_o(dub), .du_oe_o(oe));
  vdm_link_model LM (.link_clk_i(link_clk), .frame_o(frame), .dd_o(dd), .du_o(du),
    .du_byte_i(dub), .du_oe_i(oe));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.7;
    forever #24 link_clk = ~link_clk;
  end
  // ==========================================
  // tasks
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] s, input logic [7:0] d);
    @(negedge ref_clk);
    wr = 1'b1;
    sel = s;
    wd = d;
    @(negedge ref_clk);
    wr = 1'b0;
  endtask
  task automatic rreg(input logic [3:0] s, input logic [7:0] e);
    @(negedge ref_clk);
    sel = s;
    @(negedge ref_clk);
    chk({8'h00, rdat}, {8'h00, e});
  endtask
  task automatic frames(input int k);
    repeat (k * 8) @(posedge link_clk);
  endtask
  task automatic rxchk(input logic [15:0] e, input logic [15:0] m);
    logic [15:0] r;
    frames(3);
    for (int k = 0; k < 400 && rxv !== 1'b1; k++) @(negedge ref_clk);
    r = rxs;
    chk({15'h0, rxv}, 16'h0001);
    @(negedge ref_clk);
    chk(r & m, e & m);
  endtask
  task automatic push(input logic [15:0] w);
    @(negedge ref_clk);
    txv = 1'b1;
    txs = w;
    for (int k = 0; k < 400 && txr !== 1'b1; k++) @(negedge ref_clk);
    @(negedge ref_clk);
    txv = 1'b0;
  endtask
  task automatic txchk(input logic [15:0] w, input logic [15:0] e);
    repeat (5) push(w);
    frames(3);
    chk({LM.got[LM.got.size() - 2], LM.got[LM.got.size() - 1]}, e);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #400us;
    miscompares++;
    stop_test();
  end
  // ==========================================
  // tests
  initial begin
    for (int k = 0; k < 8; k++) begin
      LM.dd_tab[k] = 8'h91 + 8'(k) * 8'h30;
      LM.du_tab[k] = LM.dd_tab[k] ^ 8'h5a;
    end
    repeat (16) @(negedge ref_clk);
    rst_n = 1'b1;
    rreg(4'h1, 8'h20);
    rreg(4'h0, 8'h00);
    rreg(4'hb, 8'hbf);
    rreg(4'h5, 8'h00);
    rreg(4'hf, 8'h00);
    for (int i = 0; i < 8; i++) begin
      strap = i[2];
      wreg(4'h0, {4'h1, i[0], 3'h0});
      wreg(4'hb, {1'b0, i[1], 6'h00});
      wreg(4'h1, {2'b00, i[0], i[1], 4'h1});
      n = (i[0] ? 4 : 0) + (i[1] ^ i[2]);
      rxchk({LM.dd_tab[n], 8'h00}, 16'hff00);
      chk({14'h0, hs, spk}, {14'h0, i[0], i[1]});
    end
    txchk(16'h3c77, 16'h3c3c);
    strap = 1'b0;
    wreg(4'h0, 8'h10);
    wreg(4'hb, 8'h00);
    wreg(4'hb, 8'hc0);
    rxchk({LM.dd_tab[0], 8'h00}, 16'hff00);
    wreg(4'h1, 8'h20);
    txchk(16'ha5c3, 16'ha5a5);
    n = 0;
    repeat (100) @(negedge ref_clk) n += int'(rxv === 1'b1);
    chk(16'(n), 16'h0000);
    txv = 1'b1;
    repeat (12) @(negedge ref_clk);
    chk({15'h0, txr}, 16'h0000);
    txv = 1'b0;
    frames(12);
    chk({15'h0, txr}, 16'h0001);
    wreg(4'h0, 8'h12);
    wreg(4'h1, 8'h25);
    rxchk({LM.dd_tab[0], LM.dd_tab[1]}, 16'hffff);
    wreg(4'h0, 8'h1a);
    rxchk({LM.dd_tab[4], LM.dd_tab[5]}, 16'hffff);
    txchk(16'hb14e, 16'hb14e);
    wreg(4'h1, 8'h28);
    rxchk({LM.dd_tab[4] + LM.dd_tab[5], 8'h00}, 16'hff00);
    txchk(16'h5a00, 16'h5a5a);
    wreg(4'h1, 8'h2c);
    for (int j = 0; j < 4; j++) begin
      wreg(4'h0, {4'h0, j[0], 3'h2});
      wreg(4'hb, {1'b0, j[1], 6'h00});
      n = (j[0] ? 4 : 0) + j[1];
      rxchk({LM.dd_tab[n] + LM.du_tab[n], 8'h00}, 16'hff00);
    end
    n = LM.got.size();
    frames(2);
    chk(16'(LM.got.size()), 16'(n));
    stop_test();
  end
endmodule
`default_nettype wire
